// ===== src/wsp_cfg.svh
// Constants for the window state and processor state control block
`ifndef WSP_CFG_SVH
`define WSP_CFG_SVH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define WSP_XLEN 64
`define WSP_HALF 32
`define WSP_N_WIN 8
`define WSP_WIN_W 3
`define WSP_TL_W 3
`define WSP_ASI_W 8

// ------------------------------------------------------------
// Register select codes
// ------------------------------------------------------------
`define WSP_SEL_CWP 3'h0
`define WSP_SEL_SAVE 3'h1
`define WSP_SEL_REST 3'h2
`define WSP_SEL_OTHER 3'h3
`define WSP_SEL_CLEAN 3'h4
`define WSP_SEL_PROCESSOR_STATE_REGISTER 3'h5

// ------------------------------------------------------------
// Window register limits and reset value
// ------------------------------------------------------------
`define WSP_MAX_FULL 3'h7
`define WSP_MAX_PART 3'h6
`define WSP_WIN_RST 3'h0

// ------------------------------------------------------------
// Processor state field positions and codes
// ------------------------------------------------------------
`define WSP_PS_MM_LO 6
`define WSP_PS_MM_HI 7
`define WSP_PS_AM 3
`define WSP_PS_CLE 9
`define WSP_MM_TSO 2'h0
`define WSP_MM_RMO 2'h2
`define WSP_MM_MASK 4'h7

// ------------------------------------------------------------
// Address space codes (plain defaults)
// ------------------------------------------------------------
`define WSP_ASI_KERN 8'h04
`define WSP_ASI_KERN_LE 8'h0c
`define WSP_ASI_PRIM 8'h80

`endif

// ===== src/wsp_pkg.sv
// Types shared by the window state and processor state control block
package wsp_pkg;
`include "wsp_cfg.svh"

  typedef enum logic [2:0] {
    WSP_CWP = 3'b000,
    WSP_SAVE = 3'b001,
    WSP_REST = 3'b010,
    WSP_OTHER = 3'b011,
    WSP_CLEAN = 3'b100,
    WSP_PROCESSOR_STATE_REGISTER = 3'b101
  } wsp_sel_t;

  typedef logic [`WSP_XLEN-1:0] wsp_word_t;
  typedef logic [1:0] wsp_mm_t;
endpackage

// ===== src/wsp_win_reg.sv
// One register window state register with range clamping
`timescale 1ns/1ps
`include "wsp_cfg.svh"
module wsp_win_reg import wsp_pkg::*; #(
  parameter int WIN_W = `WSP_WIN_W,
  parameter logic [WIN_W-1:0] MAX_VAL = `WSP_MAX_FULL
) (
  input wire logic core_clk, // Core clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic wr_en, // Write strobe
  input wire logic [WIN_W-1:0] wr_val, // Trimmed write value
  output logic [WIN_W-1:0] val // Current value
);

  logic [WIN_W-1:0] val_r;
  logic [WIN_W-1:0] val_nxt;

  // Clamp writes above the legal maximum
  always_comb begin
    val_nxt = val_r;
    if (wr_en) begin
      if (wr_val > MAX_VAL) begin
        val_nxt = MAX_VAL;
      end else begin
        val_nxt = wr_val;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      val_r <= WIN_W'(`WSP_WIN_RST);
    end else begin
      val_r <= val_nxt;
    end
  end

  assign val = val_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_win_in_range: assert property (val_r <= MAX_VAL)
    else $error("window register above its maximum");
  a_win_keep_legal: assert property (wr_en && wr_val <= MAX_VAL |=> val_r == $past(wr_val))
    else $error("legal window write not stored");
endmodule

// ===== src/wsp_ctrl.sv
// Window state registers and processor state control
`timescale 1ns/1ps
`include "wsp_cfg.svh"

// Overview of operation
// - With relaxed order code selected and supported, the core runs relaxed-order programs correctly.
// - A write of an unsupported memory model code never leaves a larger code in the field.
// - A core with only total store order reads the model field as zero and ignores writes to it.
// - Above trap level zero every instruction fetch uses the kernel address space.
// - Above trap level zero implicit data accesses use kernel big or little endian space by the bit.
// - With address masking, call, jump-and-link and read-pc store only the low 32 pc bits.
// - With address masking, a trap saves only the low 32 bits of pc and next pc.
// - A window register write above window count minus one stores a value in range.
// - Window registers are between log2 of window count and five bits; upper bits read zero.
// - All five window registers share one width.
// - The core has eight windows and three-bit window registers.
// - Maximum is seven for pointer and clean count, six for the other three counts.
// - Register writes to window registers drop operand bits 63 to 3.
module wsp_ctrl import wsp_pkg::*; #(
  parameter int N_WIN = `WSP_N_WIN,
  parameter int WIN_W = `WSP_WIN_W,
  parameter int TL_W = `WSP_TL_W,
  parameter logic [3:0] MM_MASK = `WSP_MM_MASK,
  parameter logic [`WSP_ASI_W-1:0] ASI_KERN = `WSP_ASI_KERN,
  parameter logic [`WSP_ASI_W-1:0] ASI_KERN_LE = `WSP_ASI_KERN_LE,
  parameter logic [`WSP_ASI_W-1:0] ASI_PRIM = `WSP_ASI_PRIM
) (
  input wire logic core_clk, // Core clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic privileged_register_write, // Register write strobe
  input wire logic [2:0] wr_sel, // Register written
  input wire logic [`WSP_XLEN-1:0] wr_data, // Write operand
  input wire logic [2:0] rd_sel, // Register read
  output logic [`WSP_XLEN-1:0] rd_data, // Read data, one cycle later
  input wire logic [TL_W-1:0] trap_level, // Current trap level
  output logic [`WSP_ASI_W-1:0] fetch_asi, // Implicit fetch space
  output logic [`WSP_ASI_W-1:0] data_asi, // Implicit load/store space
  output logic relaxed_memory_order, // Relaxed order active
  output logic address_mask_bit, // Address masking active
  input wire logic link_en, // Call, jump-and-link or read-pc
  input wire logic [`WSP_XLEN-1:0] pc, // Program counter
  input wire logic [`WSP_XLEN-1:0] next_program_counter, // Next pc
  output logic [`WSP_XLEN-1:0] link_value, // Destination value
  input wire logic trap_take, // Trap taken this cycle
  output logic [`WSP_XLEN-1:0] trap_saved_pc, // Saved pc
  output logic [`WSP_XLEN-1:0] trap_saved_next_pc // Saved next pc
);

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------

  // Keep low half only when masking is on
  function automatic wsp_word_t pc_mask(input wsp_word_t v, input logic am);
    pc_mask = v;
    if (am) begin
      pc_mask[`WSP_XLEN-1:`WSP_HALF] = '0;
    end
  endfunction

  // Largest supported model code not above the request
  function automatic wsp_mm_t mm_pick(input wsp_mm_t req);
    mm_pick = `WSP_MM_TSO;
    for (int i = 0; i < $bits(MM_MASK); i++) begin
      if (MM_MASK[i] && i <= int'(req)) begin
        mm_pick = wsp_mm_t'(i);
      end
    end
  endfunction

  localparam logic TSO_ONLY = (MM_MASK == 4'h1);
  localparam int NREG = 5;

  // ------------------------------------------------------------
  // Window state registers
  // ------------------------------------------------------------
  logic [WIN_W-1:0] win_val [NREG];
  logic [NREG-1:0] win_wr;

  // One write strobe per window register
  always_comb begin
    for (int k = 0; k < NREG; k++) begin
      win_wr[k] = privileged_register_write && (wr_sel == 3'(k));
    end
  end

  for (genvar g = 0; g < NREG; g++) begin : g_win
    // Pointer and clean count reach the top, others stop one lower
    localparam logic [WIN_W-1:0] MAXV = (g == int'(WSP_CWP) || g == int'(WSP_CLEAN)) ?
      WIN_W'(N_WIN - 1) : WIN_W'(N_WIN - 2);
    wsp_win_reg #(.WIN_W(WIN_W), .MAX_VAL(MAXV)) u_win (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .wr_en(win_wr[g]),
      .wr_val(wr_data[WIN_W-1:0]),
      .val(win_val[g])
    );
  end

  // ------------------------------------------------------------
  // Processor state fields
  // ------------------------------------------------------------
  wsp_mm_t mm_r;
  wsp_mm_t mm_nxt;
  logic am_r;
  logic am_nxt;
  logic cle_r;
  logic cle_nxt;

  // Field updates on a processor state write
  always_comb begin
    mm_nxt = mm_r;
    am_nxt = am_r;
    cle_nxt = cle_r;
    if (privileged_register_write && wr_sel == WSP_PROCESSOR_STATE_REGISTER) begin
      am_nxt = wr_data[`WSP_PS_AM];
      cle_nxt = wr_data[`WSP_PS_CLE];
      if (!TSO_ONLY) begin
        mm_nxt = mm_pick(wr_data[`WSP_PS_MM_HI:`WSP_PS_MM_LO]);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mm_r <= `WSP_MM_TSO;
      am_r <= 1'b0;
      cle_r <= 1'b0;
    end else begin
      mm_r <= mm_nxt;
      am_r <= am_nxt;
      cle_r <= cle_nxt;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  wsp_word_t rd_data_r, rd_data_nxt;
  wsp_word_t link_r, link_nxt;
  wsp_word_t tpc_r, tpc_nxt;
  wsp_word_t trap_saved_next_pc_r, trap_saved_next_pc_nxt;
  logic [`WSP_ASI_W-1:0] fasi_r, fasi_nxt;
  logic [`WSP_ASI_W-1:0] dasi_r, dasi_nxt;
  logic rmo_r, rmo_nxt;
  logic amo_r;

  // Next values of read data, spaces and saved counters
  always_comb begin
    rd_data_nxt = '0;
    case (rd_sel)
      WSP_CWP, WSP_SAVE, WSP_REST, WSP_OTHER, WSP_CLEAN: begin
        rd_data_nxt[WIN_W-1:0] = win_val[rd_sel];
      end
      WSP_PROCESSOR_STATE_REGISTER: begin
        rd_data_nxt[`WSP_PS_MM_HI:`WSP_PS_MM_LO] = mm_r;
        rd_data_nxt[`WSP_PS_AM] = am_r;
        rd_data_nxt[`WSP_PS_CLE] = cle_r;
      end
      default: begin
        rd_data_nxt = '0;
      end
    endcase
    if (trap_level != '0) begin
      fasi_nxt = ASI_KERN;
      dasi_nxt = cle_r ? ASI_KERN_LE : ASI_KERN;
    end else begin
      fasi_nxt = ASI_PRIM;
      dasi_nxt = ASI_PRIM;
    end
    rmo_nxt = MM_MASK[`WSP_MM_RMO] && (mm_r == `WSP_MM_RMO);
    link_nxt = link_en ? pc_mask(pc, am_r) : link_r;
    tpc_nxt = trap_take ? pc_mask(pc, am_r) : tpc_r;
    trap_saved_next_pc_nxt = trap_take ? pc_mask(next_program_counter, am_r) : trap_saved_next_pc_r;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_data_r <= '0;
      link_r <= '0;
      tpc_r <= '0;
      trap_saved_next_pc_r <= '0;
      fasi_r <= ASI_PRIM;
      dasi_r <= ASI_PRIM;
      rmo_r <= 1'b0;
      amo_r <= 1'b0;
    end else begin
      rd_data_r <= rd_data_nxt;
      link_r <= link_nxt;
      tpc_r <= tpc_nxt;
      trap_saved_next_pc_r <= trap_saved_next_pc_nxt;
      fasi_r <= fasi_nxt;
      dasi_r <= dasi_nxt;
      rmo_r <= rmo_nxt;
      amo_r <= am_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign link_value = link_r;
  assign trap_saved_pc = tpc_r;
  assign trap_saved_next_pc = trap_saved_next_pc_r;
  assign fetch_asi = fasi_r;
  assign data_asi = dasi_r;
  assign relaxed_memory_order = rmo_r;
  assign address_mask_bit = amo_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_ps_write;
    privileged_register_write && wr_sel == WSP_PROCESSOR_STATE_REGISTER;
  endsequence

  sequence s_trap_masked;
    trap_take && am_r;
  endsequence

  a_mm_not_above: assert property (s_ps_write |=>
      mm_r <= $past(wr_data[`WSP_PS_MM_HI:`WSP_PS_MM_LO]))
    else $error("model field above written code");
  a_tso_only_zero: assert property (!TSO_ONLY ||
      (mm_r == '0 && rd_data[`WSP_PS_MM_HI:`WSP_PS_MM_LO] == '0))
    else $error("model field nonzero on total store order core");
  a_rmo_follow: assert property (mm_r == `WSP_MM_RMO && MM_MASK[`WSP_MM_RMO] |=>
      relaxed_memory_order)
    else $error("relaxed order not reported");
  a_fetch_kernel: assert property (trap_level != '0 |=> fetch_asi == ASI_KERN)
    else $error("fetch space not kernel above trap level zero");
  a_data_endian: assert property (trap_level != '0 |=>
      data_asi == ($past(cle_r) ? ASI_KERN_LE : ASI_KERN))
    else $error("data space does not follow endian bit");
  a_link_masked: assert property (link_en && am_r |=>
      link_value[`WSP_XLEN-1:`WSP_HALF] == '0
      && link_value[`WSP_HALF-1:0] == $past(pc[`WSP_HALF-1:0]))
    else $error("link value not masked");
  a_trap_masked: assert property (s_trap_masked |=>
      trap_saved_pc[`WSP_XLEN-1:`WSP_HALF] == '0
      && trap_saved_next_pc[`WSP_XLEN-1:`WSP_HALF] == '0
      && trap_saved_pc[`WSP_HALF-1:0] == $past(pc[`WSP_HALF-1:0])
      && trap_saved_next_pc[`WSP_HALF-1:0] == $past(next_program_counter[`WSP_HALF-1:0]))
    else $error("saved counters not masked");
  a_win_upper_zero: assert property (rd_sel < WSP_PROCESSOR_STATE_REGISTER |=>
      rd_data[`WSP_XLEN-1:WIN_W] == '0)
    else $error("window register upper bits not zero");
  a_win_trim: assert property (win_wr[0] ##1 1'b1 |->
      win_val[0] == $past(wr_data[WIN_W-1:0]))
    else $error("pointer write not trimmed to low bits");
endmodule

// ===== sim/test_window_state_and_processor_state_register_ctrl.sv
// Self-checking bench for the window state and processor state control block
`timescale 1ns/1ps
`include "wsp_cfg.svh"
module test_window_state_and_processor_state_register_ctrl import wsp_pkg::*;;
  // ----------------------------------------
  // Design signals and bench state
  // ----------------------------------------
  logic core_clk, sys_rst, privileged_register_write, link_en, trap_take;
  logic [2:0] wr_sel, rd_sel, trap_level;
  logic [63:0] wr_data, rd_data, pc, next_program_counter, link_value;
  logic [63:0] trap_saved_pc, trap_saved_next_pc;
  logic [7:0] fetch_asi, data_asi;
  logic relaxed_memory_order, address_mask_bit;
  int n_fail, num_checks;
  int win_m [5];
  int mm_m, am_m, cle_m;
  logic [15:0] lfsr_r;

  wsp_ctrl dut (.core_clk, .sys_rst, .privileged_register_write, .wr_sel, .wr_data,
    .rd_sel, .rd_data, .trap_level, .fetch_asi, .data_asi, .relaxed_memory_order,
    .address_mask_bit, .link_en, .pc, .next_program_counter, .link_value, .trap_take,
    .trap_saved_pc, .trap_saved_next_pc);

  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Pseudo-random 64-bit word from the shift register
  function automatic logic [63:0] rnd64();
    logic [63:0] v;
    v = '0;
    repeat (64) begin
      lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      v = {v[62:0], lfsr_r[0]};
    end
    return v;
  endfunction

  // Expected read word from the model
  function automatic logic [63:0] exp_reg(input int s);
    if (s < 5) return 64'(win_m[s]);
    if (s == 5) return 64'((cle_m << 9) | (mm_m << 6) | (am_m << 3));
    return 64'h0;
  endfunction

  task automatic model_rst();
    foreach (win_m[i]) win_m[i] = 0;
    mm_m = 0;
    am_m = 0;
    cle_m = 0;
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // One write pulse, then the model follows it
  // Strobe stays high when another write follows at once
  task automatic wr_reg(input logic [2:0] s, input logic [63:0] d, input bit more = 1'b0);
    int v, mx;
    privileged_register_write = 1'b1;
    wr_sel = s;
    wr_data = d;
    @(posedge core_clk);
    #1;
    if (!more) privileged_register_write = 1'b0;
    v = int'(d[2:0]);
    mx = (s == 3'h0 || s == 3'h4) ? 7 : 6;
    if (s < 3'h5) win_m[s] = (v > mx) ? mx : v;
    if (s == 3'h5) begin
      mm_m = int'(d[7:6]);
      if (mm_m == 3) mm_m = 2;
      am_m = int'(d[3]);
      cle_m = int'(d[9]);
    end
  endtask

  // Read one register, data lands one edge later
  task automatic rd_chk(input logic [2:0] s);
    rd_sel = s;
    @(posedge core_clk);
    #1;
    chk("rd_data", exp_reg(int'(s)), rd_data);
  endtask

  task automatic chk_space(input logic [2:0] t);
    trap_level = t;
    @(posedge core_clk);
    #1;
    chk("fetch_asi", (t != 0) ? 64'(`WSP_ASI_KERN) : 64'(`WSP_ASI_PRIM), 64'(fetch_asi));
    chk("data_asi", (t == 0) ? 64'(`WSP_ASI_PRIM) : (cle_m != 0) ? 64'(`WSP_ASI_KERN_LE)
      : 64'(`WSP_ASI_KERN), 64'(data_asi));
  endtask

  // Link and trap capture in the same cycle
  task automatic chk_capture();
    logic [63:0] p, n, m;
    p = rnd64();
    n = rnd64();
    m = (am_m != 0) ? 64'h0000_0000_ffff_ffff : 64'hffff_ffff_ffff_ffff;
    pc = p;
    next_program_counter = n;
    link_en = 1'b1;
    trap_take = 1'b1;
    @(posedge core_clk);
    #1;
    link_en = 1'b0;
    trap_take = 1'b0;
    chk("link_value", p & m, link_value);
    chk("trap_saved_pc", p & m, trap_saved_pc);
    chk("trap_saved_next_pc", n & m, trap_saved_next_pc);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n_fail = 0;
    num_checks = 0;
    lfsr_r = 16'h8c36;
    sys_rst = 1'b1;
    privileged_register_write = 1'b0;
    wr_sel = 3'h0;
    wr_data = 64'h0;
    rd_sel = 3'h0;
    trap_level = 3'h0;
    link_en = 1'b0;
    trap_take = 1'b0;
    pc = 64'h0;
    next_program_counter = 64'h0;
    model_rst();
    repeat (10) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    // Reset state of every register, both spaces, relaxed order and link value
    for (int s = 0; s < 8; s++) rd_chk(3'(s));
    chk_space(3'h0);
    chk("relaxed_memory_order", 64'h0, 64'(relaxed_memory_order));
    chk("link_value", 64'h0, link_value);
    // Every value into every window register, junk in upper operand bits
    for (int s = 0; s < 5; s++) begin
      for (int v = 0; v < 8; v++) begin
        wr_reg(3'(s), (rnd64() & ~64'h7) | 64'(v));
        rd_chk(3'(s));
      end
    end
    // Back-to-back random writes, unused selects included
    for (int i = 0; i < 24; i++) wr_reg(3'(rnd64()), rnd64(), i < 23);
    for (int s = 0; s < 8; s++) rd_chk(3'(s));
    // Well-behaved software keeps window values at most count minus two
    for (int s = 0; s < 5; s++) begin
      wr_reg(3'(s), (rnd64() & ~64'h7) | (rnd64() % 64'd7));
      rd_chk(3'(s));
    end
    // All model codes with mask and endian combinations
    for (int k = 0; k < 16; k++) begin
      wr_reg(3'h5, (rnd64() & ~64'h2c8) | 64'(k[1:0]) << 6 | 64'(k[2]) << 3 | 64'(k[3]) << 9);
      rd_chk(3'h5);
      chk("relaxed_memory_order", 64'(mm_m == 2), 64'(relaxed_memory_order));
      chk("address_mask_bit", 64'(am_m), 64'(address_mask_bit));
      chk_space(3'h1);
      chk_space(3'h7);
      chk_space(3'h0);
      chk_capture();
    end
    // Reset again in mid-run
    sys_rst = 1'b1;
    @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    model_rst();
    rd_chk(3'h0);
    rd_chk(3'h5);
    chk("link_value", 64'h0, link_value);
    chk("trap_saved_pc", 64'h0, trap_saved_pc);
    chk("trap_saved_next_pc", 64'h0, trap_saved_next_pc);
    chk("address_mask_bit", 64'h0, 64'(address_mask_bit));
    chk("relaxed_memory_order", 64'h0, 64'(relaxed_memory_order));
    chk_space(3'h1);
    stop_test();
  end

  // Run-time limit
  initial begin
    repeat (20000) @(posedge core_clk);
    $display("CHECK FAILED run length expected finish seen limit");
    n_fail++;
    stop_test();
  end
endmodule
